// >>> wsen_defines.svh
// Overview of operation
// - A sense flag becomes 1 when the selected trigger occurs on an enabled channel; otherwise reads 0.
// - Software writes can never set a sense flag; only triggers can.
// - Writing 1 to a sense bit clears it; writing 0 leaves it.
// - Enabled channel trigger raises a wake-up request to power management.
// - Disabled channel trigger raises no request and is dropped, not held.
// - Second group disabled channel passes its input straight to the interrupt controller.
// - Second group enabled channel output comes through edge select and sense flag.
// - Sense flags of groups two, three, four sit at offsets 05h, 06h, 07h.
// - Four eight-bit enable registers at 08h to 0Bh, all reset to 0.
// - Edge bit 0 picks rising edge, 1 falling.
// - Any disabled channel presents its input directly to the interrupt controller.
`ifndef WSEN_DEFINES_SVH
`define WSEN_DEFINES_SVH

// Register indices; byte address is four times the index
`define WSEN_IDX_SENSE1 10'h004
`define WSEN_IDX_SENSE2 10'h005
`define WSEN_IDX_SENSE3 10'h006
`define WSEN_IDX_SENSE4 10'h007
`define WSEN_IDX_EN1 10'h008
`define WSEN_IDX_EN2 10'h009
`define WSEN_IDX_EN3 10'h00A
`define WSEN_IDX_EN4 10'h00B
`define WSEN_IDX_STATUS 10'h00C
`define WSEN_IDX_MASK 10'h00D

// Reset values
`define WSEN_EN_RST 32'h0000_0000
`define WSEN_MASK_RST 4'h0
`define WSEN_STATUS_RST 4'h0
`define WSEN_FLAG_RST 1'b0

// Field layout
`define WSEN_GROUP_W 8
`define WSEN_GROUPS 4
`define WSEN_CHANNELS 32

`endif

// >>> wsen_pkg.sv
package wsen_pkg;

	typedef enum logic [3:0] {
		WSEN_SEL_NONE = 4'b0000,
		WSEN_SEL_SENSE1 = 4'b0001,
		WSEN_SEL_SENSE2 = 4'b0010,
		WSEN_SEL_SENSE3 = 4'b0011,
		WSEN_SEL_SENSE4 = 4'b0100,
		WSEN_SEL_EN1 = 4'b0101,
		WSEN_SEL_EN2 = 4'b0110,
		WSEN_SEL_EN3 = 4'b0111,
		WSEN_SEL_EN4 = 4'b1000,
		WSEN_SEL_STATUS = 4'b1001,
		WSEN_SEL_MASK = 4'b1010
	} wsen_sel_t;

endpackage

// >>> wsen_channel.sv
`timescale 1ns/10ps
`include "wsen_defines.svh"

module wsen_channel (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic wake_in,
	input wire logic enable,
	input wire logic falling_sel,
	input wire logic clear_hit,
	output logic flag,
	output logic chan_out,
	output logic set_pulse
);

	logic sync1_r, sync1_nxt;
	logic sync2_r, sync2_nxt;
	logic prev_r, prev_nxt;
	logic flag_r, flag_nxt;
	logic out_r, out_nxt;
	logic trig;

	always_comb begin
		sync1_nxt = wake_in;
		sync2_nxt = sync1_r;
		prev_nxt = sync2_r;
		// Edge from the two settled samples only
		trig = falling_sel ? (prev_r & ~sync2_r) : (~prev_r & sync2_r);
		// Disabled channel drops the event rather than latching it
		set_pulse = enable & trig;
		// Set wins over a same-cycle write-one clear
		flag_nxt = set_pulse | (flag_r & ~clear_hit);
		// Disabled: raw level bypasses the pending logic
		out_nxt = enable ? flag_nxt : sync2_r;
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			sync1_r <= 1'b0;
			sync2_r <= 1'b0;
			prev_r <= 1'b0;
			flag_r <= `WSEN_FLAG_RST;
			out_r <= 1'b0;
		end else begin
			sync1_r <= sync1_nxt;
			sync2_r <= sync2_nxt;
			prev_r <= prev_nxt;
			flag_r <= flag_nxt;
			out_r <= out_nxt;
		end
	end

	assign flag = flag_r;
	assign chan_out = out_r;

endmodule

// >>> wsen_wake_ctrl.sv
// The APB interface to the registers is this design's own decision.
`timescale 1ns/10ps
`include "wsen_defines.svh"

module wsen_wake_ctrl (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [7:0] wake_inputs_first_group,
	input wire logic [7:0] wake_inputs_second_group,
	input wire logic [7:0] wake_inputs_third_group,
	input wire logic [7:0] wake_inputs_fourth_group,
	input wire logic [7:0] edge_select_first_group,
	input wire logic [7:0] edge_select_second_group,
	input wire logic [7:0] edge_select_third_group,
	input wire logic [7:0] edge_select_fourth_group,
	output logic [7:0] wake_outputs_first_group,
	output logic [7:0] wake_outputs_second_group,
	output logic [7:0] wake_outputs_third_group,
	output logic [7:0] wake_outputs_fourth_group,
	output logic wake_request,
	output logic irq
);

	// Flat per-channel views, group one in the low byte
	logic [31:0] wake_in_all;
	logic [31:0] edge_all;
	logic [31:0] flags;
	logic [31:0] chan_out;
	logic [31:0] set_pulse;
	logic [31:0] clear_vec;

	// Software state
	logic [31:0] en_r, en_nxt;
	logic [3:0] mask_r, mask_nxt;
	logic [3:0] status_r, status_nxt;
	logic [31:0] prdata_r, prdata_nxt;
	logic err_r, err_nxt;
	logic wake_r, wake_nxt;

	// Bus decode
	wsen_pkg::wsen_sel_t sel;
	logic [9:0] idx;
	logic setup_ph;
	logic access_ph;
	logic wr_en;
	logic rd_status;
	logic [31:0] rd_mux;
	logic [3:0] group_evt;

	assign wake_in_all = {wake_inputs_fourth_group, wake_inputs_third_group,
		wake_inputs_second_group, wake_inputs_first_group};
	assign edge_all = {edge_select_fourth_group, edge_select_third_group,
		edge_select_second_group, edge_select_first_group};

	genvar gi;
	generate
		for (gi = 0; gi < `WSEN_CHANNELS; gi = gi + 1) begin : g_chan
			wsen_channel u_chan (
				.clk_sys(clk_sys),
				.sys_rst(sys_rst),
				.wake_in(wake_in_all[gi]),
				.enable(en_r[gi]),
				.falling_sel(edge_all[gi]),
				.clear_hit(clear_vec[gi]),
				.flag(flags[gi]),
				.chan_out(chan_out[gi]),
				.set_pulse(set_pulse[gi])
			);
		end
	endgenerate

	assign wake_outputs_first_group = chan_out[7:0];
	assign wake_outputs_second_group = chan_out[15:8];
	assign wake_outputs_third_group = chan_out[23:16];
	assign wake_outputs_fourth_group = chan_out[31:24];

	// Address decode; only word-aligned addresses are mapped
	assign idx = paddr[11:2];
	always_comb begin
		if (paddr[1:0] != 2'b00) begin
			sel = wsen_pkg::WSEN_SEL_NONE;
		end else if (idx == `WSEN_IDX_SENSE1) begin
			sel = wsen_pkg::WSEN_SEL_SENSE1;
		end else if (idx == `WSEN_IDX_SENSE2) begin
			sel = wsen_pkg::WSEN_SEL_SENSE2;
		end else if (idx == `WSEN_IDX_SENSE3) begin
			sel = wsen_pkg::WSEN_SEL_SENSE3;
		end else if (idx == `WSEN_IDX_SENSE4) begin
			sel = wsen_pkg::WSEN_SEL_SENSE4;
		end else if (idx == `WSEN_IDX_EN1) begin
			sel = wsen_pkg::WSEN_SEL_EN1;
		end else if (idx == `WSEN_IDX_EN2) begin
			sel = wsen_pkg::WSEN_SEL_EN2;
		end else if (idx == `WSEN_IDX_EN3) begin
			sel = wsen_pkg::WSEN_SEL_EN3;
		end else if (idx == `WSEN_IDX_EN4) begin
			sel = wsen_pkg::WSEN_SEL_EN4;
		end else if (idx == `WSEN_IDX_STATUS) begin
			sel = wsen_pkg::WSEN_SEL_STATUS;
		end else if (idx == `WSEN_IDX_MASK) begin
			sel = wsen_pkg::WSEN_SEL_MASK;
		end else begin
			sel = wsen_pkg::WSEN_SEL_NONE;
		end
	end

	// Zero-wait access: read data is captured in setup so it leaves a flop
	assign setup_ph = psel & ~penable;
	assign access_ph = psel & penable;
	assign pready = 1'b1;
	assign wr_en = access_ph & pwrite & pstrb[0] & (sel != wsen_pkg::WSEN_SEL_NONE);
	assign rd_status = access_ph & ~pwrite & (sel == wsen_pkg::WSEN_SEL_STATUS);

	always_comb begin
		rd_mux = 32'h0000_0000;
		case (sel)
			wsen_pkg::WSEN_SEL_SENSE1: rd_mux[7:0] = flags[7:0];
			wsen_pkg::WSEN_SEL_SENSE2: rd_mux[7:0] = flags[15:8];
			wsen_pkg::WSEN_SEL_SENSE3: rd_mux[7:0] = flags[23:16];
			wsen_pkg::WSEN_SEL_SENSE4: rd_mux[7:0] = flags[31:24];
			wsen_pkg::WSEN_SEL_EN1: rd_mux[7:0] = en_r[7:0];
			wsen_pkg::WSEN_SEL_EN2: rd_mux[7:0] = en_r[15:8];
			wsen_pkg::WSEN_SEL_EN3: rd_mux[7:0] = en_r[23:16];
			wsen_pkg::WSEN_SEL_EN4: rd_mux[7:0] = en_r[31:24];
			wsen_pkg::WSEN_SEL_STATUS: rd_mux[3:0] = status_r;
			wsen_pkg::WSEN_SEL_MASK: rd_mux[3:0] = mask_r;
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	// Sense writes only ever clear; no path sets a flag from the bus
	always_comb begin
		clear_vec = 32'h0000_0000;
		if (wr_en) begin
			case (sel)
				wsen_pkg::WSEN_SEL_SENSE1: clear_vec[7:0] = pwdata[7:0];
				wsen_pkg::WSEN_SEL_SENSE2: clear_vec[15:8] = pwdata[7:0];
				wsen_pkg::WSEN_SEL_SENSE3: clear_vec[23:16] = pwdata[7:0];
				wsen_pkg::WSEN_SEL_SENSE4: clear_vec[31:24] = pwdata[7:0];
				default: clear_vec = 32'h0000_0000;
			endcase
		end
	end

	always_comb begin
		en_nxt = en_r;
		mask_nxt = mask_r;
		if (wr_en) begin
			case (sel)
				wsen_pkg::WSEN_SEL_EN1: en_nxt[7:0] = pwdata[7:0];
				wsen_pkg::WSEN_SEL_EN2: en_nxt[15:8] = pwdata[7:0];
				wsen_pkg::WSEN_SEL_EN3: en_nxt[23:16] = pwdata[7:0];
				wsen_pkg::WSEN_SEL_EN4: en_nxt[31:24] = pwdata[7:0];
				wsen_pkg::WSEN_SEL_MASK: mask_nxt = pwdata[3:0];
				default: en_nxt = en_r;
			endcase
		end
	end

	// One sticky event per group; a new event beats the read that clears
	always_comb begin
		for (int g = 0; g < `WSEN_GROUPS; g++) begin
			group_evt[g] = |set_pulse[g*`WSEN_GROUP_W +: `WSEN_GROUP_W];
		end
		status_nxt = (rd_status ? 4'h0 : status_r) | group_evt;
	end

	always_comb begin
		prdata_nxt = setup_ph ? rd_mux : prdata_r;
		err_nxt = setup_ph ? (sel == wsen_pkg::WSEN_SEL_NONE) : err_r;
		// Flags of disabled channels are kept but do not wake
		wake_nxt = |(flags & en_r);
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			en_r <= `WSEN_EN_RST;
			mask_r <= `WSEN_MASK_RST;
			status_r <= `WSEN_STATUS_RST;
			prdata_r <= 32'h0000_0000;
			err_r <= 1'b0;
			wake_r <= 1'b0;
		end else begin
			en_r <= en_nxt;
			mask_r <= mask_nxt;
			status_r <= status_nxt;
			prdata_r <= prdata_nxt;
			err_r <= err_nxt;
			wake_r <= wake_nxt;
		end
	end

	assign prdata = prdata_r;
	assign pslverr = access_ph & err_r;
	assign wake_request = wake_r;
	assign irq = |(status_r & mask_r);

endmodule

// >>> wsen_chk_asserts.sv
`timescale 1ns/10ps
module wsen_chk (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [7:0] wake_inputs_second_group,
	input wire logic [7:0] wake_outputs_second_group,
	input wire logic wake_request,
	input wire logic irq
);
	wire acc = psel && penable;
	wire wr = acc && pwrite;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	AST_ERR_ONLY_ACCESS: assert property (pslverr |-> acc)
		else $error("pslverr outside access");
	AST_SENSE_MAPPED: assert property (acc && paddr inside {12'h014, 12'h018, 12'h01c} |-> !pslverr)
		else $error("sense access refused");
	AST_UNALIGNED_ERR: assert property (psel && !penable && paddr[1:0] != 2'h0 ##1 acc |-> pslverr)
		else $error("unaligned access accepted");
	AST_READY_FIRST: assert property (acc |-> pready)
		else $error("access not completed");
	AST_RESET_QUIET: assert property ($fell(sys_rst) |-> !wake_request && !irq && wake_outputs_second_group == 8'h00)
		else $error("outputs active after reset");
	AST_REQ_HELD: assert property ($fell(wake_request) |-> $past(wr, 2))
		else $error("wake request dropped without write");
	AST_IRQ_HELD: assert property ($fell(irq) |-> $past(acc))
		else $error("irq dropped without access");
	AST_OUT_CAUSE: assert property ($rose(|wake_outputs_second_group) && !$past(wr)
		&& !$past(wr, 2)
		|-> $past(wake_inputs_second_group, 3) != $past(wake_inputs_second_group, 4))
		else $error("output rose without input edge");
endmodule
bind wsen_wake_ctrl wsen_chk u_chk (.clk_sys, .sys_rst, .psel, .penable, .pwrite, .paddr, .pready,
	.pslverr, .wake_inputs_second_group, .wake_outputs_second_group, .wake_request, .irq);

// >>> wsen_pm_model.sv
`timescale 1ns/10ps
module wsen_pm_model (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic wake_request,
	output logic [7:0] wake_count
);
	logic req_d_r;
	// Counts wake-ups, not cycles: a long request is one wake-up
	always_ff @(posedge clk_sys) begin
		req_d_r <= sys_rst ? 1'b0 : wake_request;
		if (sys_rst)
			wake_count <= 8'h00;
		else if (wake_request && !req_d_r)
			wake_count <= wake_count + 8'h01;
	end
endmodule

// >>> test_wakeup_sense_enable.sv
`timescale 1ns/10ps
module test_wakeup_sense_enable;
	logic clk_sys, sys_rst, psel, penable, pwrite, pready, pslverr, wake_request, irq, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [3:0] pstrb;
	logic [7:0] win [4];
	logic [7:0] esel [4];
	logic [7:0] wout [4];
	logic [7:0] wake_count;
	int miscompares, checks, g;
	wsen_wake_ctrl uut (.clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .wake_inputs_first_group(win[0]),
		.wake_inputs_second_group(win[1]), .wake_inputs_third_group(win[2]),
		.wake_inputs_fourth_group(win[3]), .edge_select_first_group(esel[0]),
		.edge_select_second_group(esel[1]), .edge_select_third_group(esel[2]),
		.edge_select_fourth_group(esel[3]), .wake_outputs_first_group(wout[0]),
		.wake_outputs_second_group(wout[1]), .wake_outputs_third_group(wout[2]),
		.wake_outputs_fourth_group(wout[3]), .wake_request(wake_request), .irq(irq));
	wsen_pm_model pm (.clk_sys(clk_sys), .sys_rst(sys_rst), .wake_request(wake_request),
		.wake_count(wake_count));
	initial begin
		clk_sys = 0;
		forever #20 clk_sys = ~clk_sys;
	end
	task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD %s exp %h got %h", nm, exp, got);
		end
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
		@(posedge clk_sys);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1;
		@(posedge clk_sys);
		while (pready !== 1'b1) @(posedge clk_sys);
		q = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] q;
		apb(1, a, d, q);
	endtask
	task rd(input logic [11:0] a, input logic [31:0] exp);
		logic [31:0] q;
		apb(0, a, 0, q);
		chk("register", q, exp);
	endtask
	task print_verdict;
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		#(40 * 3000);
		miscompares++;
		print_verdict;
	end
	initial begin
		sys_rst = 1;
		{psel, penable, pwrite, paddr, pwdata} = 0;
		pstrb = 4'hf;
		win = '{default: 8'h00};
		esel = '{8'h00, 8'h00, 8'h01, 8'h00};
		repeat (16) @(posedge clk_sys);
		sys_rst <= 0;
		for (g = 0; g < 4; g++) rd(12'h020 + 4 * g, 0);
		rd(12'h040, 0);
		chk("pslverr", err, 1);
		rd(12'h026, 0);
		chk("pslverr", err, 1);
		wr(12'h024, 32'h0000_00a5);
		rd(12'h024, 32'h0000_00a5);
		chk("pslverr", err, 0);
		pstrb <= 4'he;
		wr(12'h028, 32'h0000_00ff);
		pstrb <= 4'hf;
		rd(12'h028, 32'h0000_0000);
		wr(12'h034, 32'h0000_0004);
		for (g = 1; g < 4; g++) begin
			wr(12'h020 + 4 * g, 32'h0000_0001);
			win[g] <= 8'h03;
			repeat (5) @(posedge clk_sys);
			chk("raw out", wout[g], g == 2 ? 8'h02 : 8'h03);
			win[g] <= 8'h00;
			repeat (5) @(posedge clk_sys);
			chk("flag out", wout[g], 8'h01);
			chk("request", wake_request, 1);
			rd(12'h010 + 4 * g, 32'h0000_0001);
			wr(12'h010 + 4 * g, 32'h0000_0000);
			rd(12'h010 + 4 * g, 32'h0000_0001);
			wr(12'h010 + 4 * g, 32'h0000_00ff);
			wr(12'h010 + 4 * g, 32'h0000_00ff);
			rd(12'h010 + 4 * g, 32'h0000_0000);
			chk("request", wake_request, 0);
		end
		chk("wake count", wake_count, 8'h03);
		chk("irq", irq, 1);
		rd(12'h030, 32'h0000_000e);
		@(posedge clk_sys);
		chk("irq", irq, 0);
		win[0] <= 8'h80;
		repeat (5) @(posedge clk_sys);
		chk("bypass out", wout[0], 8'h80);
		rd(12'h010, 32'h0000_0000);
		rd(12'h030, 32'h0000_0000);
		chk("wake count", wake_count, 8'h03);
		win[0] <= 8'h00;
		repeat (4) @(posedge clk_sys);
		wr(12'h020, 32'h0000_0001);
		// Edge reaches the flag on the access edge of the clearing write
		win[0] <= 8'h01;
		wr(12'h010, 32'h0000_0001);
		rd(12'h010, 32'h0000_0001);
		chk("wake count", wake_count, 8'h04);
		print_verdict;
	end
endmodule
